// ### core/internal_clock_freq_select.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "clk_sel_defines.svh"

// Overview of operation
// - internal clock comes from a 500 kHz base; eight frequencies, top 16 MHz.
// - internal or external source is chosen by the configuration option field.
// - a three-bit source option field, fixed at programming, selects internal modes.
// - a postscaler divides the internal source by 1, 2, 4 or 8.
// - lock option set feeds the 16 MHz locked source into the postscaler.
// - with lock set, selectable rates are 16, 8, 4 and 2 MHz.
// - with lock clear, rates are 500, 250, 125, 62.5 kHz from base.
// - any reset loads the select field with 10: 8 MHz or 250 kHz.
// - a new select value applies at once, no start-up delay.
// - clock-out mode frees input pin, drives output pin with frequency over 4.
// - plain internal mode frees both oscillator pins to general I/O.

module internal_clock_freq_select
   import clk_sel_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic base_osc_tick,
   input wire logic locked_osc_tick,
   input wire logic [2:0] cfg_osc_source,
   input wire logic cfg_lock_16mhz,
   input wire logic osc_input_pin_in,
   output logic osc_input_pin_out,
   output logic osc_input_pin_oe_n,
   input wire logic osc_output_pin_in,
   output logic osc_output_pin_out,
   output logic osc_output_pin_oe_n,
   output logic sys_clk_tick
);

   generate
      if (ADDR_W < 4) begin : g_bad_addr
         $error("address width too small for the register map");
      end
   endgenerate

   // ----------------------------------------
   // configuration word capture
   // ----------------------------------------
   logic strap_done;
   logic lock_16mhz_option;
   logic [2:0] osc_source_option;
   osc_mode_t mode;

   // options are fuses: caught once after reset release, never changed by software
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         strap_done <= 1'b0;
         lock_16mhz_option <= 1'b0;
         osc_source_option <= `FOSC_RESET;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         lock_16mhz_option <= cfg_lock_16mhz;
         osc_source_option <= cfg_osc_source;
      end
   end

   always_comb begin
      if (osc_source_option == `FOSC_INT_IO) begin
         mode = MODE_INT_IO;
      end else if (osc_source_option == `FOSC_INT_CLKOUT) begin
         mode = MODE_INT_CLKOUT;
      end else begin
         mode = MODE_EXTERNAL;
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] pin_raw;
   logic [1:0] pin_meta;
   logic [1:0] pin_level;
   logic ext_prev;
   logic ext_tick;

   assign pin_raw = {osc_output_pin_in, osc_input_pin_in};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin_sync
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               pin_meta[gi] <= 1'b0;
               pin_level[gi] <= 1'b0;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_level[gi] <= pin_meta[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= pin_level[0];
      end
   end

   // rising edge of an external clock on the input pin
   assign ext_tick = pin_level[0] && !ext_prev;

   // ----------------------------------------
   // source select and postscaler
   // ----------------------------------------
   logic [1:0] freq_select_field;
   logic src_tick;
   logic int_tick;

   assign src_tick = lock_16mhz_option ? locked_osc_tick : base_osc_tick;

   postscaler #(
      .CNT_W(3)
   ) u_postscaler (
      .clk(clk),
      .reset(reset),
      .src_tick(src_tick),
      .div_sel(freq_select_field),
      .out_tick(int_tick)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sys_clk_tick <= 1'b0;
      end else if (!strap_done) begin
         sys_clk_tick <= 1'b0;
      end else if (mode == MODE_EXTERNAL) begin
         sys_clk_tick <= ext_tick;
      end else begin
         sys_clk_tick <= int_tick;
      end
   end

   // ----------------------------------------
   // clock-out divider and pins
   // ----------------------------------------
   logic [1:0] clkout_phase;
   logic clkout_level;
   logic phase_odd;
   logic [1:0] pin_drive;
   logic [1:0] pin_enable;
   logic out_pin_en;

   assign clkout_level = clkout_phase[1];
   assign phase_odd = clkout_phase[0];
   assign out_pin_en = pin_enable[1];

   // two phase bits toggle the pin every second tick: a period of four ticks
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clkout_phase <= 2'h0;
      end else if (mode != MODE_INT_CLKOUT) begin
         clkout_phase <= 2'h0;
      end else if (int_tick) begin
         clkout_phase <= clkout_phase + 2'h1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         osc_input_pin_out <= 1'b0;
         osc_input_pin_oe_n <= 1'b1;
         osc_output_pin_out <= 1'b0;
         osc_output_pin_oe_n <= 1'b1;
      end else begin
         case (mode)
            MODE_INT_CLKOUT: begin
               osc_input_pin_out <= pin_drive[0];
               osc_input_pin_oe_n <= !pin_enable[0];
               osc_output_pin_out <= clkout_level;
               osc_output_pin_oe_n <= 1'b0;
            end
            MODE_INT_IO: begin
               osc_input_pin_out <= pin_drive[0];
               osc_input_pin_oe_n <= !pin_enable[0];
               osc_output_pin_out <= pin_drive[1];
               osc_output_pin_oe_n <= !pin_enable[1];
            end
            default: begin
               // external modes: pins belong to the oscillator circuit
               osc_input_pin_out <= 1'b0;
               osc_input_pin_oe_n <= 1'b1;
               osc_output_pin_out <= 1'b0;
               osc_output_pin_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------
   // bus write channel
   // ----------------------------------------
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic [7:0] waddr8;

   assign do_write = aw_held && w_held && !bvalid;
   assign waddr8 = 8'(aw_addr);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         awready <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_held <= 1'b1;
         aw_addr <= awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !bvalid) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wready <= 1'b0;
         w_held <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_held <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (!w_held && !bvalid) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         if (waddr8 == `OSC_CTRL_OFFSET || waddr8 == `OSC_STATUS_OFFSET ||
             waddr8 == `PIN_IO_OFFSET || waddr8 == `FREQ_HZ_OFFSET) begin
            bresp <= `RESP_OKAY;
         end else begin
            bresp <= `RESP_SLVERR;
         end
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         freq_select_field <= `FSEL_RESET;
      end else if (do_write && waddr8 == `OSC_CTRL_OFFSET && wstrb_q[0]) begin
         freq_select_field <= wdata_q[`FSEL_MSB:`FSEL_LSB];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         {pin_enable, pin_drive} <= `PIN_IO_RESET;
      end else if (do_write && waddr8 == `PIN_IO_OFFSET && wstrb_q[0]) begin
         pin_drive <= wdata_q[`PIN_DRIVE_LSB+:2];
         pin_enable <= wdata_q[`PIN_ENABLE_LSB+:2];
      end
   end

   // ----------------------------------------
   // bus read channel
   // ----------------------------------------
   logic [31:0] freq_hz;
   logic [31:0] read_word;
   logic read_ok;
   logic [7:0] raddr8;

   assign raddr8 = 8'(araddr);

   // rate now selected, in hertz; the shift is 3 minus the select code
   assign freq_hz = (lock_16mhz_option ? `LOCKED_OSC_HZ : `BASE_OSC_HZ)
                    >> (~freq_select_field);

   always_comb begin
      read_word = 32'h00000000;
      read_ok = 1'b1;
      if (raddr8 == `OSC_CTRL_OFFSET) begin
         read_word[`FSEL_MSB:`FSEL_LSB] = freq_select_field;
      end else if (raddr8 == `OSC_STATUS_OFFSET) begin
         read_word[8:0] = {strap_done, pin_level, mode, osc_source_option,
                           lock_16mhz_option};
      end else if (raddr8 == `PIN_IO_OFFSET) begin
         read_word[5:0] = {pin_level, pin_enable, pin_drive};
      end else if (raddr8 == `FREQ_HZ_OFFSET) begin
         read_word = freq_hz;
      end else begin
         read_ok = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= read_word;
         rresp <= read_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_reset_select: assert property (
      @(posedge clk) disable iff (reset)
      $rose(strap_done) |-> freq_select_field == `FSEL_RESET)
      else $error("select field not 10 after reset");

   a_write_select: assert property (
      @(posedge clk) disable iff (reset)
      do_write && waddr8 == `OSC_CTRL_OFFSET && wstrb_q[0]
      |=> freq_select_field == wdata_q[`FSEL_MSB:`FSEL_LSB])
      else $error("select field write not applied");

   a_tick_cause: assert property (
      @(posedge clk) disable iff (reset)
      int_tick |-> $past(src_tick))
      else $error("postscaler tick without a source tick");

   a_locked_pass: assert property (
      @(posedge clk) disable iff (reset)
      strap_done && lock_16mhz_option && locked_osc_tick
      && freq_select_field == 2'h3 |=> int_tick)
      else $error("locked source not passed at divide by 1");

   a_base_only: assert property (
      @(posedge clk) disable iff (reset)
      strap_done && !lock_16mhz_option && !base_osc_tick |=> !int_tick)
      else $error("unlocked rate not taken from base oscillator");

   a_rate_report: assert property (
      @(posedge clk) disable iff (reset)
      freq_select_field == 2'h2 |->
      freq_hz == (lock_16mhz_option ? 32'h007A1200 : 32'h0003D090))
      else $error("default selection is not 8 MHz or 250 kHz");

   a_clkout_pin: assert property (
      @(posedge clk) disable iff (reset)
      mode == MODE_INT_CLKOUT && $stable(clkout_level)
      |=> !osc_output_pin_oe_n && osc_output_pin_out == $past(clkout_level))
      else $error("clock-out pin not driven by divided clock");

   a_clkout_div4: assert property (
      @(posedge clk) disable iff (reset)
      mode == MODE_INT_CLKOUT && $changed(clkout_level)
      |-> $past(int_tick) && $past(phase_odd))
      else $error("clock-out does not toggle every second tick");

   a_io_release: assert property (
      @(posedge clk) disable iff (reset)
      mode == MODE_INT_IO && $stable(out_pin_en)
      |=> osc_output_pin_oe_n == !$past(out_pin_en))
      else $error("output pin not released to general I/O");

   a_options_fixed: assert property (
      @(posedge clk) disable iff (reset)
      strap_done && $past(strap_done)
      |-> $stable(lock_16mhz_option) && $stable(osc_source_option))
      else $error("configuration options changed after capture");

   a_ext_select: assert property (
      @(posedge clk) disable iff (reset)
      strap_done && mode == MODE_EXTERNAL |=> sys_clk_tick == $past(ext_tick))
      else $error("external mode does not follow the pin clock");

endmodule : internal_clock_freq_select

// ### core/clk_sel_defines.svh
`ifndef CLK_SEL_DEFINES_SVH
`define CLK_SEL_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OSC_CTRL_OFFSET 8'h00
`define OSC_STATUS_OFFSET 8'h04
`define PIN_IO_OFFSET 8'h08
`define FREQ_HZ_OFFSET 8'h0C

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define FSEL_LSB 0
`define FSEL_MSB 1
`define FSEL_RESET 2'h2
`define PIN_DRIVE_LSB 0
`define PIN_ENABLE_LSB 2
`define PIN_IO_RESET 4'h0

// ----------------------------------------
// oscillator source option codes
// ----------------------------------------
`define FOSC_INT_IO 3'h4
`define FOSC_INT_CLKOUT 3'h5
`define FOSC_RESET 3'h4

// ----------------------------------------
// source frequencies
// ----------------------------------------
`define BASE_OSC_HZ 32'h0007A120
`define LOCKED_OSC_HZ 32'h00F42400

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### core/clk_sel_pkg.sv
package clk_sel_pkg;

   typedef enum logic [1:0] {
      MODE_EXTERNAL = 2'b00,
      MODE_INT_IO = 2'b01,
      MODE_INT_CLKOUT = 2'b10
   } osc_mode_t;

   typedef enum logic [1:0] {
      DIV_8 = 2'b00,
      DIV_4 = 2'b01,
      DIV_2 = 2'b10,
      DIV_1 = 2'b11
   } freq_sel_t;

endpackage : clk_sel_pkg

// ### core/postscaler.sv
`timescale 1ns/100ps
module postscaler
   import clk_sel_pkg::*;
#(
   parameter int CNT_W = 3
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic src_tick,
   input wire logic [1:0] div_sel,
   output logic out_tick
);

   generate
      if (CNT_W != 3) begin : g_bad_width
         $error("postscaler needs a 3-bit counter for divide by 8");
      end
   endgenerate

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] mask;

   // free-running counter: a new divisor acts on the very next source tick
   always_comb begin
      case (freq_sel_t'(div_sel))
         DIV_1: mask = 3'h0;
         DIV_2: mask = 3'h1;
         DIV_4: mask = 3'h3;
         default: mask = 3'h7;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= '0;
      end else if (src_tick) begin
         cnt <= cnt + 3'h1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_tick <= 1'b0;
      end else begin
         out_tick <= src_tick && ((cnt & mask) == 3'h0);
      end
   end

endmodule : postscaler

// ### sim/test_internal_clock_freq_select.sv
`timescale 1ns/100ps
`include "clk_sel_defines.svh"

module test_internal_clock_freq_select
   import clk_sel_pkg::*;
   ;
   typedef struct {
      logic lock;
      freq_sel_t code;
      logic [31:0] hz;
      logic [7:0] ticks;
   } row_t;

   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, sys_clk_tick;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd, s0, sys_cnt = 32'h0, pin_cnt = 32'h0;
   logic base_osc_tick = 1'b0, locked_osc_tick = 1'b0, cfg_lock_16mhz = 1'b1;
   logic [2:0] cfg_osc_source = `FOSC_INT_IO;
   logic osc_input_pin_in = 1'b0, last_pin = 1'b0;
   logic osc_input_pin_out, osc_input_pin_oe_n, osc_output_pin_out, osc_output_pin_oe_n;
   int failures = 0, compares = 0, cur;
   row_t rows [8];

   internal_clock_freq_select dut (.clk(clk), .reset(reset), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .base_osc_tick(base_osc_tick), .locked_osc_tick(locked_osc_tick),
      .cfg_osc_source(cfg_osc_source), .cfg_lock_16mhz(cfg_lock_16mhz),
      .osc_input_pin_in(osc_input_pin_in), .osc_input_pin_out(osc_input_pin_out),
      .osc_input_pin_oe_n(osc_input_pin_oe_n),
      // the output pin reads back its own level; released, it is pulled low
      .osc_output_pin_in(!osc_output_pin_oe_n && osc_output_pin_out),
      .osc_output_pin_out(osc_output_pin_out), .osc_output_pin_oe_n(osc_output_pin_oe_n),
      .sys_clk_tick(sys_clk_tick));

   always #50 clk = ~clk;

   // counters run free; tests take differences so no second writer is needed
   always @(posedge clk) begin
      if (sys_clk_tick === 1'b1) begin
         sys_cnt <= sys_cnt + 32'h1;
      end
      if (osc_output_pin_out !== last_pin) begin
         pin_cnt <= pin_cnt + 32'h1;
      end
      last_pin <= osc_output_pin_out;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      bit ad, wd;
      ad = 0;
      wd = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (!ad && awready === 1'b1) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read

   // the unused source pulses as often but out of phase, so picking the wrong one shifts the ticks in time, not in the count
   task automatic src_ticks(input int n, input logic lk);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         base_osc_tick <= !lk;
         locked_osc_tick <= lk;
         @(posedge clk);
         base_osc_tick <= 1'b0;
         locked_osc_tick <= 1'b0;
         @(posedge clk);
         base_osc_tick <= lk;
         locked_osc_tick <= !lk;
         @(posedge clk);
         base_osc_tick <= 1'b0;
         locked_osc_tick <= 1'b0;
      end
      repeat (6) @(posedge clk);
   endtask : src_ticks

   task automatic do_reset(input logic [2:0] src, input logic lk);
      @(posedge clk);
      cfg_osc_source <= src;
      cfg_lock_16mhz <= lk;
      reset <= 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : do_reset

   task automatic final_report();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   // ----------------------------------------
   // watchdog: about twenty-five times the expected run
   // ----------------------------------------
   initial begin
      #3000000;
      failures++;
      final_report();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rows = '{'{1'b1, DIV_1, 32'h00F42400, 8'h10}, '{1'b1, DIV_2, 32'h007A1200, 8'h08},
               '{1'b1, DIV_4, 32'h003D0900, 8'h04}, '{1'b1, DIV_8, 32'h001E8480, 8'h02},
               '{1'b0, DIV_1, 32'h0007A120, 8'h10}, '{1'b0, DIV_2, 32'h0003D090, 8'h08},
               '{1'b0, DIV_4, 32'h0001E848, 8'h04}, '{1'b0, DIV_8, 32'h0000F424, 8'h02}};
      cur = 2;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      foreach (rows[i]) begin
         if (int'(rows[i].lock) != cur) begin
            do_reset(`FOSC_INT_IO, rows[i].lock);
            cur = int'(rows[i].lock);
            axi_read(`OSC_CTRL_OFFSET, rd, rs);
            check(rd & 32'h3, {30'h0, `FSEL_RESET});
            axi_read(`FREQ_HZ_OFFSET, rd, rs);
            check(rd, rows[i].lock ? 32'h007A1200 : 32'h0003D090);
         end
         axi_write(`OSC_CTRL_OFFSET, {30'h0, rows[i].code}, 4'hF, rs);
         check({30'h0, rs}, {30'h0, `RESP_OKAY});
         axi_read(`FREQ_HZ_OFFSET, rd, rs);
         check(rd, rows[i].hz);
         s0 = sys_cnt;
         src_ticks(16, rows[i].lock);
         check(sys_cnt - s0, {24'h0, rows[i].ticks});
      end
      $display("test frequency table done");

      // bus corner cases; select is 00 from the last row
      axi_write(`OSC_CTRL_OFFSET, 32'h3, 4'h0, rs);
      axi_read(`OSC_CTRL_OFFSET, rd, rs);
      check(rd & 32'h3, 32'h0);
      axi_write(8'h10, 32'h3, 4'hF, rs);
      check({30'h0, rs}, {30'h0, `RESP_SLVERR});
      axi_read(8'h10, rd, rs);
      check({30'h0, rs}, {30'h0, `RESP_SLVERR});
      axi_write(`FREQ_HZ_OFFSET, 32'h0, 4'hF, rs);
      check({30'h0, rs}, {30'h0, `RESP_OKAY});
      axi_read(`FREQ_HZ_OFFSET, rd, rs);
      check(rd, 32'h0000F424);
      axi_write(`OSC_STATUS_OFFSET, 32'hFFFFFFFF, 4'hF, rs);
      check({30'h0, rs}, {30'h0, `RESP_OKAY});
      axi_read(`OSC_STATUS_OFFSET, rd, rs);
      check(rd & 32'h1FF, 32'h00000118);
      $display("test bus corners done");

      // io mode: both pins free, no clock on the output pin
      check({30'h0, osc_input_pin_oe_n, osc_output_pin_oe_n}, 32'h3);
      s0 = pin_cnt;
      src_ticks(8, 1'b0);
      check(pin_cnt - s0, 32'h0);
      axi_write(`PIN_IO_OFFSET, 32'hE, 4'hF, rs);
      repeat (2) @(posedge clk);
      check({28'h0, osc_input_pin_oe_n, osc_output_pin_oe_n, osc_input_pin_out,
             osc_output_pin_out}, 32'h1);
      axi_read(`PIN_IO_OFFSET, rd, rs);
      check(rd & 32'h3F, 32'h0000002E);
      $display("test io mode done");

      // clock-out mode: output pin toggles twice per four internal ticks
      do_reset(`FOSC_INT_CLKOUT, 1'b1);
      axi_read(`OSC_STATUS_OFFSET, rd, rs);
      check(rd & 32'h13F, 32'h0000012B);
      check({30'h0, osc_input_pin_oe_n, osc_output_pin_oe_n}, 32'h2);
      axi_write(`OSC_CTRL_OFFSET, {30'h0, DIV_1}, 4'hF, rs);
      s0 = pin_cnt;
      src_ticks(32, 1'b1);
      check(pin_cnt - s0, 32'h10);
      axi_write(`OSC_CTRL_OFFSET, {30'h0, DIV_2}, 4'hF, rs);
      s0 = pin_cnt;
      src_ticks(32, 1'b1);
      check(pin_cnt - s0, 32'h8);
      $display("test clock-out mode done");

      // external mode: internal ticks ignored, input pin rises clock the system
      do_reset(3'h0, 1'b0);
      axi_read(`OSC_STATUS_OFFSET, rd, rs);
      check(rd & 32'h13F, 32'h00000100);
      check({30'h0, osc_input_pin_oe_n, osc_output_pin_oe_n}, 32'h3);
      s0 = sys_cnt;
      src_ticks(16, 1'b0);
      check(sys_cnt - s0, 32'h0);
      s0 = sys_cnt;
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         osc_input_pin_in <= 1'b1;
         repeat (4) @(posedge clk);
         osc_input_pin_in <= 1'b0;
         repeat (4) @(posedge clk);
      end
      repeat (6) @(posedge clk);
      check(sys_cnt - s0, 32'h5);
      $display("test external mode done");
      final_report();
   end
endmodule : test_internal_clock_freq_select
